// ### src/part_pkg.sv
// package: register map, field positions and types for the pwm auto-reload timer
package part_pkg;
   // ************************************************************
   // register byte offsets
   // ************************************************************
   localparam logic [7:0] PART_OFF_CSR    = 8'h00; // timer_control_status_register
   localparam logic [7:0] PART_OFF_CAR    = 8'h04; // counter_access_register
   localparam logic [7:0] PART_OFF_ARR    = 8'h08; // auto_reload_value_register
   localparam logic [7:0] PART_OFF_OUTPUT_CONTROL_REGISTER  = 8'h0c; // output_control_register
   localparam logic [7:0] PART_OFF_DCR0   = 8'h10; // duty_cycle_register 0..3 at +4
   localparam logic [7:0] PART_OFF_ICCSR  = 8'h20; // capture_control_status_register
   localparam logic [7:0] PART_OFF_ICR0   = 8'h24; // capture_value_register 0
   localparam logic [7:0] PART_OFF_ICR1   = 8'h28; // capture_value_register 1
   localparam logic [7:0] PART_OFF_MODE   = 8'h2c; // halt mode control
   // ************************************************************
   // field positions
   // ************************************************************
   localparam int PART_CSR_EXTERNAL_CLOCK_SELECT = 7;
   localparam int PART_CSR_CC   = 4;
   localparam int PART_CSR_TCE  = 3;
   localparam int PART_CSR_FORCE_RELOAD_BIT = 2;
   localparam int PART_CSR_OIE  = 1;
   localparam int PART_CSR_OVF  = 0;
   localparam int PART_OUTPUT_CONTROL_REGISTER_OE = 4;   // oe in [7:4], polarity in [3:0]
   localparam int PART_IC_CF    = 4;   // cf in [5:4]
   localparam int PART_IC_CIE   = 2;   // cie in [3:2]
   localparam int PART_IC_CS    = 0;   // edge select in [1:0], 1 = rising
   // ************************************************************
   // reset values and bus answers
   // ************************************************************
   localparam logic [7:0] PART_RST_BYTE = 8'h00;
   localparam logic [6:0] PART_RST_PRE  = 7'h00;
   localparam logic [1:0] PART_RESP_OK  = 2'b00;
   localparam logic [1:0] PART_RESP_ERR = 2'b10;

   typedef struct packed {
      logic       external_clock_select;
      logic [2:0] cc;
      logic       counter_enable_bit;
      logic       force_reload_bit;
      logic       overflow_interrupt_enable;
      logic       ovf;
   } part_csr_t;
endpackage

// ### src/part_timer.sv
// module: pwm auto-reload timer with axi4-lite register slave
//
// Behaviour
// - counter increments on each prescaled tick
// - counter readable and writable while running
// - overflow reloads counter, prescaler untouched
// - prescaler divides by two to cc
// - prescaler input: cpu or external clock
// - enable clear freezes prescaler and counter
// - reset clears counter, prescaler, selects cpu
// - force reload written with tce set, or counter write, clears prescaler
// - four compare registers loaded at overflow
// - output enable drives pwm pin push-pull
// - pwm frequency is tick over 256-reload
// - overflow sets polarity, compare match restores
// - reload zero gives 1/256 resolution
// - pwm generation stops in halt
// - overflow sets sticky flag, optional interrupt
// - external events counted to overflow flag
// - capture edge latches counter, sets flag
// - capture locked until register read
// - capture interrupt pending while flag enabled
// - capture edges wake system from halt
`timescale 1ns/1ps
`default_nettype none
module part_timer
   import part_pkg::*;
#(
   parameter int CHANNELS = 4,
   parameter int CAPTURES = 2
) (
   input  wire logic                aclk,
   input  wire logic                aresetn,
   input  wire logic [7:0]          s_axi_awaddr,
   input  wire logic                s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire logic [31:0]         s_axi_wdata,
   input  wire logic [3:0]          s_axi_wstrb,
   input  wire logic                s_axi_wvalid,
   output logic                     s_axi_wready,
   output logic [1:0]               s_axi_bresp,
   output logic                     s_axi_bvalid,
   input  wire logic                s_axi_bready,
   input  wire logic [7:0]          s_axi_araddr,
   input  wire logic                s_axi_arvalid,
   output logic                     s_axi_arready,
   output logic [31:0]              s_axi_rdata,
   output logic [1:0]               s_axi_rresp,
   output logic                     s_axi_rvalid,
   input  wire logic                s_axi_rready,
   input  wire logic                ext_clock_in,
   input  wire logic [CAPTURES-1:0] capture_input_pin,
   output logic [CHANNELS-1:0]      modulated_output_pin,
   output logic [CHANNELS-1:0]      modulated_output_oe_n,
   output logic                     overflow_irq,
   output logic                     capture_irq,
   output logic                     halt_wakeup
);
   // ************************************************************
   // elaboration checks
   // ************************************************************
   if (CHANNELS != 4) begin : g_bad_ch
      $error("part_timer: CHANNELS must be 4");
   end
   if (CAPTURES != 2) begin : g_bad_cap
      $error("part_timer: CAPTURES must be 2");
   end

   // ************************************************************
   // state
   // ************************************************************
   part_csr_t  csr;
   logic [7:0] counter;
   logic [6:0] prescaler;
   logic [7:0] reload_value;
   logic [3:0] channel_output_enable;
   logic [3:0] channel_polarity_bit;
   logic [7:0] duty_cycle_register [4];
   logic [7:0] hidden_compare_value [4];
   logic [3:0] pwm_level;
   logic [1:0] capture_flag;
   logic [1:0] capture_interrupt_enable;
   logic [1:0] capture_edge_select;
   logic [7:0] capture_value [2];
   logic [1:0] cap_prev;
   logic       ext_prev;
   logic       halt_mode;

   // bus
   logic       aw_held;
   logic       w_held;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic       wr_fire;
   logic       rd_fire;

   // ************************************************************
   // axi4-lite write and read channels
   // ************************************************************
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_fire       = s_axi_arvalid && s_axi_arready;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end
   end

   logic wr_hit;
   always_comb begin
      wr_hit = 1'b0;
      case (aw_addr)
         PART_OFF_CSR, PART_OFF_CAR, PART_OFF_ARR, PART_OFF_OUTPUT_CONTROL_REGISTER,
         PART_OFF_ICCSR, PART_OFF_MODE,
         PART_OFF_DCR0, PART_OFF_DCR0 + 8'h04, PART_OFF_DCR0 + 8'h08,
         PART_OFF_DCR0 + 8'h0c, PART_OFF_ICR0, PART_OFF_ICR1: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= PART_RESP_OK;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? PART_RESP_OK : PART_RESP_ERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // only lane 0 carries data; a write with wstrb[0] low stores nothing
   logic       wr_en;
   logic [7:0] wb;
   assign wr_en = wr_fire && w_strb[0];
   assign wb    = w_data[7:0];

   logic [7:0] next_rdata;
   logic       rd_hit;
   always_comb begin
      next_rdata = 8'h00;
      rd_hit     = 1'b1;
      case (s_axi_araddr)
         PART_OFF_CSR:   next_rdata = csr;
         PART_OFF_CAR:   next_rdata = counter;
         PART_OFF_ARR:   next_rdata = reload_value;
         PART_OFF_OUTPUT_CONTROL_REGISTER: next_rdata = {channel_output_enable, channel_polarity_bit};
         PART_OFF_DCR0:  next_rdata = duty_cycle_register[0];
         PART_OFF_DCR0 + 8'h04: next_rdata = duty_cycle_register[1];
         PART_OFF_DCR0 + 8'h08: next_rdata = duty_cycle_register[2];
         PART_OFF_DCR0 + 8'h0c: next_rdata = duty_cycle_register[3];
         PART_OFF_ICCSR: next_rdata = {2'b00, capture_flag, capture_interrupt_enable,
                                       capture_edge_select};
         PART_OFF_ICR0:  next_rdata = capture_value[0];
         PART_OFF_ICR1:  next_rdata = capture_value[1];
         PART_OFF_MODE:  next_rdata = {7'h00, halt_mode};
         default:        rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= PART_RESP_OK;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= {24'h000000, next_rdata};
         s_axi_rresp  <= rd_hit ? PART_RESP_OK : PART_RESP_ERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ************************************************************
   // prescaler and counter
   // ************************************************************
   logic       input_tick;
   logic       count_tick;
   logic       overflow;
   logic       car_write;
   logic       force_load;
   logic [6:0] next_prescaler;

   // external clock is sampled; a rising edge is one input tick
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_prev <= 1'b0;
      end else begin
         ext_prev <= ext_clock_in;
      end
   end

   // external clock does not run in halt
   assign input_tick = csr.external_clock_select ? (ext_clock_in && !ext_prev && !halt_mode)
                                : 1'b1;
   assign next_prescaler = prescaler + 7'h01;
   // tap n fires when the low n bits roll over; tap 0 passes every tick
   assign count_tick = csr.counter_enable_bit && input_tick &&
                       ((prescaler & ((7'h01 << csr.cc) - 7'h01)) ==
                        ((7'h01 << csr.cc) - 7'h01));
   assign overflow   = count_tick && (counter == 8'hff);
   assign car_write  = wr_en && aw_addr == PART_OFF_CAR;
   assign force_load = wr_en && aw_addr == PART_OFF_CSR && wb[PART_CSR_FORCE_RELOAD_BIT]
                       && wb[PART_CSR_TCE];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prescaler <= PART_RST_PRE;
      end else if (car_write || force_load) begin
         prescaler <= PART_RST_PRE;
      end else if (csr.counter_enable_bit && input_tick) begin
         prescaler <= next_prescaler;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         counter <= PART_RST_BYTE;
      end else if (car_write) begin
         counter <= wb;
      end else if (force_load) begin
         counter <= reload_value;
      end else if (overflow) begin
         counter <= reload_value;
      end else if (count_tick) begin
         counter <= counter + 8'h01;
      end
   end

   // ************************************************************
   // control registers
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         csr <= '0;
      end else begin
         if (wr_en && aw_addr == PART_OFF_CSR) begin
            csr.external_clock_select <= wb[PART_CSR_EXTERNAL_CLOCK_SELECT];
            csr.cc   <= wb[PART_CSR_CC +: 3];
            csr.counter_enable_bit  <= wb[PART_CSR_TCE];
            csr.overflow_interrupt_enable  <= wb[PART_CSR_OIE];
         end
         // force reload acts once and reads back as zero
         csr.force_reload_bit <= 1'b0;
         // set wins over a software clear in the same cycle
         if (overflow) begin
            csr.ovf <= 1'b1;
         end else if (wr_en && aw_addr == PART_OFF_CSR && !wb[PART_CSR_OVF]) begin
            csr.ovf <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reload_value          <= PART_RST_BYTE;
         channel_output_enable <= 4'h0;
         channel_polarity_bit  <= 4'h0;
         halt_mode             <= 1'b0;
         for (int i = 0; i < 4; i++) begin
            duty_cycle_register[i] <= PART_RST_BYTE;
         end
      end else if (wr_en) begin
         if (aw_addr == PART_OFF_ARR) begin
            reload_value <= wb;
         end
         if (aw_addr == PART_OFF_OUTPUT_CONTROL_REGISTER) begin
            channel_output_enable <= wb[PART_OUTPUT_CONTROL_REGISTER_OE +: 4];
            channel_polarity_bit  <= wb[3:0];
         end
         if (aw_addr == PART_OFF_MODE) begin
            halt_mode <= wb[0];
         end
         for (int i = 0; i < 4; i++) begin
            if (aw_addr == PART_OFF_DCR0 + 8'(4 * i)) begin
               duty_cycle_register[i] <= wb;
            end
         end
      end
   end

   // ************************************************************
   // pwm channels
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < 4; i++) begin
            hidden_compare_value[i] <= PART_RST_BYTE;
         end
         pwm_level <= 4'h0;
      end else if (!halt_mode) begin
         for (int i = 0; i < 4; i++) begin
            if (overflow) begin
               hidden_compare_value[i] <= duty_cycle_register[i];
               pwm_level[i]            <= channel_polarity_bit[i];
            end else if (count_tick && counter + 8'h01 == hidden_compare_value[i]) begin
               // match on the value just reached; compare at or below reload never hits
               pwm_level[i] <= !channel_polarity_bit[i];
            end
         end
      end
   end

   always_comb begin
      for (int i = 0; i < 4; i++) begin
         modulated_output_pin[i]  = channel_output_enable[i] && pwm_level[i];
         modulated_output_oe_n[i] = !channel_output_enable[i];
      end
   end

   // ************************************************************
   // input capture
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cap_prev <= 2'b00;
      end else begin
         cap_prev <= capture_input_pin;
      end
   end

   logic [1:0] cap_edge;
   logic [1:0] cap_read;
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         cap_edge[i] = capture_edge_select[i] ? (capture_input_pin[i] && !cap_prev[i])
                                              : (!capture_input_pin[i] && cap_prev[i]);
      end
      cap_read[0] = rd_fire && s_axi_araddr == PART_OFF_ICR0;
      cap_read[1] = rd_fire && s_axi_araddr == PART_OFF_ICR1;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         capture_flag <= 2'b00;
         capture_value[0] <= PART_RST_BYTE;
         capture_value[1] <= PART_RST_BYTE;
      end else begin
         for (int i = 0; i < 2; i++) begin
            // a new edge while the flag stands is dropped until the read
            if (cap_edge[i] && (!capture_flag[i] || cap_read[i])) begin
               capture_value[i] <= counter;
               capture_flag[i]  <= 1'b1;
            end else if (cap_read[i]) begin
               capture_flag[i]  <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         capture_interrupt_enable <= 2'b00;
         capture_edge_select      <= 2'b00;
      end else if (wr_en && aw_addr == PART_OFF_ICCSR) begin
         capture_interrupt_enable <= wb[PART_IC_CIE +: 2];
         capture_edge_select      <= wb[PART_IC_CS +: 2];
      end
   end

   // ************************************************************
   // requests
   // ************************************************************
   assign overflow_irq = csr.ovf && csr.overflow_interrupt_enable;
   assign capture_irq  = |(capture_flag & capture_interrupt_enable);
   assign halt_wakeup  = halt_mode && capture_irq;
endmodule // part_timer
`default_nettype wire

// ### tb/part_timer_sva.sv
// checker: port-level timing and output properties of the timer
`timescale 1ns/1ps
`default_nettype none
module part_timer_sva
   import part_pkg::*;
#(
   parameter int CHANNELS = 4,
   parameter int CAPTURES = 2
) (
   input wire logic                aclk,
   input wire logic                aresetn,
   input wire logic                s_axi_awvalid,
   input wire logic                s_axi_awready,
   input wire logic                s_axi_wvalid,
   input wire logic                s_axi_wready,
   input wire logic                s_axi_bvalid,
   input wire logic                s_axi_bready,
   input wire logic                s_axi_arvalid,
   input wire logic                s_axi_arready,
   input wire logic                s_axi_rvalid,
   input wire logic                s_axi_rready,
   input wire logic [1:0]          s_axi_rresp,
   input wire logic [31:0]         s_axi_rdata,
   input wire logic [CHANNELS-1:0] modulated_output_pin,
   input wire logic [CHANNELS-1:0] modulated_output_oe_n,
   input wire logic                overflow_irq,
   input wire logic                capture_irq,
   input wire logic                halt_wakeup
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ********************
   // bus handshake
   // ********************
   sequence seq_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence seq_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   AST_WR_ANSWER: assert property (seq_wr_taken |-> ##[1:3] s_axi_bvalid)
      else $error("write response missing");
   AST_WR_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   AST_WR_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pends");
   AST_RD_ANSWER: assert property (seq_rd_taken |=> s_axi_rvalid)
      else $error("read data late");
   AST_RD_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated");
   AST_ERR_ZERO: assert property (s_axi_rvalid && s_axi_rresp == PART_RESP_ERR
      |-> s_axi_rdata == 32'h0)
      else $error("error read carries data");
   // ********************
   // outputs and flags
   // ********************
   AST_PWM_OFF: assert property ((modulated_output_pin & modulated_output_oe_n) == '0)
      else $error("disabled channel drives high");
   // flags only drop by software, so a fall needs a recent bus access
   AST_OVF_STICKY: assert property ($fell(overflow_irq) |->
      $past(s_axi_wvalid) || $past(s_axi_wvalid, 2) || $past(s_axi_wvalid, 3) ||
      $past(s_axi_wvalid, 4))
      else $error("overflow request dropped without write");
   AST_CAP_PEND: assert property ($fell(capture_irq) |->
      $past(s_axi_arvalid) || $past(s_axi_arvalid, 2) || $past(s_axi_wvalid, 2) ||
      $past(s_axi_wvalid, 3) || $past(s_axi_wvalid, 4))
      else $error("capture request dropped without access");
   AST_WAKE: assert property (halt_wakeup |-> capture_irq)
      else $error("wake without capture request");
endmodule // part_timer_sva
`default_nettype wire

// ### tb/part_timer_tb.sv
// testbench: bus, counter, pwm and capture scenarios for the timer
`timescale 1ns/1ps
`default_nettype none
module part_timer_tb
   import part_pkg::*;
;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, ext_clock_in;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, v;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  capture_input_pin;
   wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire logic   overflow_irq, capture_irq, halt_wakeup;
   wire logic [1:0]  s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   wire logic [3:0]  modulated_output_pin, modulated_output_oe_n;
   logic [1:0]  wq[$];
   logic [65:0] rq[$], note;
   logic [7:0]  duty[4], cfg[3] = '{8'hff, 8'hf0, 8'h0f};
   int          bad_count, checks_done, seed, ones[4];

   part_timer DUT (.*);

   initial aclk = 1'b0;
   always #5 aclk = ~aclk;
   // ********************
   // shared tasks
   // ********************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = PART_RESP_OK);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      wq.push_back(r);
      fork
         begin
            do @(negedge aclk); while (!s_axi_awready);
            @(posedge aclk);
            s_axi_awvalid <= 1'b0;
         end
         begin
            do @(negedge aclk); while (!s_axi_wready);
            @(posedge aclk);
            s_axi_wvalid <= 1'b0;
         end
      join
      do @(negedge aclk); while (!s_axi_bvalid);
      @(posedge aclk);
      s_axi_bready <= 1'b0;
      @(negedge aclk);
   endtask
   // masked bits of the answer are noted as don't care
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m,
                     output logic [31:0] d, input logic [1:0] r = PART_RESP_OK);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      rq.push_back({24'hffffff, m, 24'h0, e, r});
      do @(negedge aclk); while (!s_axi_arready);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      do @(negedge aclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
      @(negedge aclk);
   endtask
   task automatic setcap(input int i, input logic val);
      @(posedge aclk);
      capture_input_pin[i] <= val;
      repeat (4) @(posedge aclk);
      @(negedge aclk);
   endtask
   task automatic tick();
      @(posedge aclk);
      ext_clock_in <= 1'b1;
      repeat (3) @(posedge aclk);
      ext_clock_in <= 1'b0;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
   endtask
   // counts the high cycles of every pwm pin over n cycles
   task automatic count(input int n);
      ones = '{default: 0};
      repeat (n) begin
         @(negedge aclk);
         foreach (ones[i]) ones[i] += modulated_output_pin[i];
      end
   endtask
   task automatic summarize();
      $display("mismatches %0d of %0d comparisons", bad_count, checks_done);
      if (bad_count == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ********************
   // response monitor
   // ********************
   always @(negedge aclk) begin
      if (s_axi_bvalid && s_axi_bready) begin
         chk({30'h0, s_axi_bresp}, {30'h0, wq.pop_front()});
      end
      if (s_axi_rvalid && s_axi_rready) begin
         note = rq.pop_front();
         chk(s_axi_rdata & note[65:34], note[33:2]);
         chk({30'h0, s_axi_rresp}, {30'h0, note[1:0]});
      end
   end
   // generous bound: the whole sequence needs about seven thousand cycles
   initial begin
      repeat (40000) @(posedge aclk);
      bad_count++;
      summarize();
   end
   // ********************
   // main sequence
   // ********************
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {ext_clock_in, capture_input_pin, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      seed = 32'h7c44;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(negedge aclk);
      chk({28'h0, modulated_output_oe_n}, 32'hf);
      rd(PART_OFF_CSR, 8'h00, 8'hff, v);
      rd(PART_OFF_CAR, 8'h00, 8'hff, v);
      rd(8'h30, 8'h00, 8'hff, v, PART_RESP_ERR);
      wr(8'h30, 8'h5a, PART_RESP_ERR);
      wr(PART_OFF_CAR, 8'h42);
      // a write without lane 0 must leave the counter alone
      @(posedge aclk) s_axi_wstrb <= 4'he;
      wr(PART_OFF_CAR, 8'h11);
      @(posedge aclk) s_axi_wstrb <= 4'hf;
      repeat (20) @(posedge aclk);
      rd(PART_OFF_CAR, 8'h42, 8'hff, v);
      wr(PART_OFF_ARR, 8'h80);
      wr(PART_OFF_CSR, 8'h7c);
      rd(PART_OFF_CAR, 8'h80, 8'hff, v);
      wr(PART_OFF_CSR, 8'h7a);
      wr(PART_OFF_CAR, 8'hff);
      repeat (140) @(negedge aclk);
      chk({31'h0, overflow_irq}, 32'h1);
      rd(PART_OFF_CAR, 8'h80, 8'hff, v);
      rd(PART_OFF_CSR, 8'h7b, 8'hff, v);
      wr(PART_OFF_CSR, 8'h72);
      repeat (300) @(negedge aclk);
      chk({31'h0, overflow_irq}, 32'h0);
      wr(PART_OFF_ARR, 8'h00);
      for (int n = 0; n < 8; n++) begin
         wr(PART_OFF_CSR, {1'b0, 3'(n), 4'h8});
         wr(PART_OFF_CAR, 8'h00);
         repeat (16 << n) @(posedge aclk);
         rd(PART_OFF_CAR, 8'h00, 8'h00, v);
         chk({31'h0, v[7:0] >= 8'd16 && v[7:0] <= 8'd23}, 32'h1);
      end
      wr(PART_OFF_CSR, 8'h08);
      foreach (duty[i]) begin
         duty[i] = 8'h01 + 8'($unsigned($random(seed)) % 255);
         wr(PART_OFF_DCR0 + 8'(4 * i), duty[i]);
      end
      foreach (cfg[k]) begin
         wr(PART_OFF_OUTPUT_CONTROL_REGISTER, cfg[k]);
         repeat (300) @(negedge aclk);
         count(256);
         foreach (ones[i]) begin
            chk(ones[i], !cfg[k][4+i] ? 0 : cfg[k][i] ? duty[i] : 256 - duty[i]);
         end
         chk({28'h0, modulated_output_oe_n}, {28'h0, ~cfg[k][7:4]});
      end
      // reload 0x80 halves the period; compare 0xc0 leaves 64 cycles at polarity
      wr(PART_OFF_ARR, 8'h80);
      wr(PART_OFF_DCR0, 8'hc0);
      wr(PART_OFF_OUTPUT_CONTROL_REGISTER, 8'h11);
      repeat (300) @(negedge aclk);
      count(128);
      chk(ones[0], 32'd64);
      wr(PART_OFF_MODE, 8'h01);
      count(128);
      chk(ones[0] % 128, 0);
      wr(PART_OFF_MODE, 8'h00);
      // stop the cpu count first so an overflow cannot beat the flag clear below
      wr(PART_OFF_CSR, 8'h88);
      wr(PART_OFF_ARR, 8'hfd);
      wr(PART_OFF_CSR, 8'h8a);
      wr(PART_OFF_CAR, 8'hfd);
      repeat (2) tick();
      chk({31'h0, overflow_irq}, 32'h0);
      tick();
      chk({31'h0, overflow_irq}, 32'h1);
      rd(PART_OFF_CAR, 8'hfd, 8'hff, v);
      wr(PART_OFF_CSR, 8'h00);
      wr(PART_OFF_CAR, 8'h42);
      wr(PART_OFF_ICCSR, 8'h05);
      setcap(0, 1'b1);
      chk({31'h0, capture_irq}, 32'h1);
      rd(PART_OFF_ICCSR, 8'h15, 8'hff, v);
      wr(PART_OFF_CAR, 8'h55);
      setcap(0, 1'b0);
      setcap(0, 1'b1);
      chk({31'h0, capture_irq}, 32'h1);
      rd(PART_OFF_ICR0, 8'h42, 8'hff, v);
      chk({31'h0, capture_irq}, 32'h0);
      wr(PART_OFF_MODE, 8'h01);
      setcap(0, 1'b0);
      setcap(0, 1'b1);
      chk({31'h0, halt_wakeup}, 32'h1);
      rd(PART_OFF_ICR0, 8'h55, 8'hff, v);
      chk({31'h0, halt_wakeup}, 32'h0);
      wr(PART_OFF_MODE, 8'h00);
      wr(PART_OFF_ICCSR, 8'h08);
      setcap(1, 1'b1);
      chk({31'h0, capture_irq}, 32'h0);
      setcap(1, 1'b0);
      chk({31'h0, capture_irq}, 32'h1);
      rd(PART_OFF_ICR1, 8'h55, 8'hff, v);
      summarize();
   end
endmodule // part_timer_tb
bind part_timer part_timer_sva #(.CHANNELS(CHANNELS), .CAPTURES(CAPTURES)) u_sva (.*);
`default_nettype wire
